// >>> include/dur_defs.vh
// Constants shared by the dual serial channel pin block
`ifndef DUR_DEFS_VH
`define DUR_DEFS_VH

// Register index within one channel (byte address = ch*stride + idx*4)
`define DUR_IDX_TXD   3'h0
`define DUR_IDX_RXD   3'h1
`define DUR_IDX_MCTL  3'h2
`define DUR_IDX_FEAT  3'h3
`define DUR_IDX_IEN   3'h4
`define DUR_IDX_STAT  3'h5
`define DUR_IDX_IST   3'h6
`define DUR_IDX_IMSK  3'h7
`define DUR_CH_STRIDE 8'h20

// Modem control bits
`define DUR_MC_DTR    0
`define DUR_MC_RTS    1
`define DUR_MC_OP2    3
`define DUR_MC_IR     6
// Feature and interrupt-enable bits for automatic flow control
`define DUR_FE_ARTS   6
`define DUR_FE_ACTS   7
// Interrupt status bits
`define DUR_IS_RXD    0
`define DUR_IS_TXD    1
`define DUR_IS_RXE    2
`define DUR_IS_MDM    3
// Line status bits
`define DUR_ST_RXF    0
`define DUR_ST_TXB    1
`define DUR_ST_TXF    2
`define DUR_ST_CTS    4
`define DUR_ST_DSR    5
`define DUR_ST_RI     6
`define DUR_ST_CD     7

// Reset values
`define DUR_RST_REG   8'h00
// Clock cycles per serial bit, and infrared pulse as a fraction of a bit
`define DUR_BIT_CYC   16'd16
`define DUR_IR_NUM    16'd3
`define DUR_IR_DEN    16'd16
// AXI responses
`define DUR_RESP_OK   2'h0
`define DUR_RESP_ERR  2'h2

`endif

// >>> rtl/dur_chan.v
// One serial channel: transmitter, receiver, infrared coding, flow pins
`timescale 1ns/1ps
`include "dur_defs.vh"

module dur_chan #(
  parameter [15:0] BIT_CYC = `DUR_BIT_CYC
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       txLoad,
  input  wire [7:0] txByte,
  input  wire       rxRead,
  input  wire       irMode,
  input  wire       autoCts,
  input  wire       autoRts,
  input  wire       rtsBit,
  input  wire       ctsN,
  input  wire       serialIn,
  output reg        serialOut,
  output reg        rtsN,
  output reg        rxReadyN,
  output reg        txBusy,
  output reg        txFull,
  output reg        rxFull,
  output reg  [7:0] rxByte,
  output reg        txDone,
  output reg        rxDone,
  output reg        rxErr
);
  localparam [15:0] IR_CYC =
    (BIT_CYC * `DUR_IR_NUM + `DUR_IR_DEN - 16'd1) / `DUR_IR_DEN;
  localparam [15:0] HALF = (BIT_CYC >> 1) - 16'd1;
  localparam [1:0] R_IDLE = 2'h0, R_START = 2'h1, R_DATA = 2'h2,
                   R_STOP = 2'h3;

  reg [7:0]  txHold_r;
  reg [9:0]  txSh_r;
  reg [3:0]  txBits_r;
  reg [15:0] txCnt_r;
  reg [15:0] irHold_r;
  reg        rxLine_r;
  reg [1:0]  rxSt_r;
  reg [15:0] rxCnt_r;
  reg [3:0]  rxBits_r;
  reg [7:0]  rxSh_r;
  wire       ctsHold = autoCts & ctsN;
  wire       txGo    = txFull & ~txBusy & ~ctsHold;
  wire       curBit  = txBusy ? txSh_r[0] : 1'b1;
  wire       irPulse = txBusy & ~txSh_r[0] &
                       (txCnt_r > BIT_CYC - 16'd1 - IR_CYC);
  wire       rxGot   = (rxSt_r == R_STOP) && (rxCnt_r == 16'h0000) &&
                       rxLine_r;
  wire       fullNxt = rxGot | (rxFull & ~rxRead);

  // ----
  // Transmitter
  // ----
  // Reset holds the line high; a byte waits in hold while CTS is off under auto CTS
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txHold_r  <= 8'h00;
      txFull    <= 1'b0;
      txSh_r    <= 10'h3FF;
      txBits_r  <= 4'h0;
      txCnt_r   <= 16'h0000;
      txBusy    <= 1'b0;
      txDone    <= 1'b0;
      serialOut <= 1'b1;
    end else begin
      txDone <= 1'b0;
      if (txLoad && !txFull) begin
        txHold_r <= txByte;
        txFull   <= 1'b1;
      end
      if (txGo) begin
        txSh_r   <= {1'b1, txHold_r, 1'b0};
        txBits_r <= 4'hA;
        txCnt_r  <= BIT_CYC - 16'd1;
        txBusy   <= 1'b1;
        txFull   <= 1'b0;
      end else if (txBusy) begin
        if (txCnt_r == 16'h0000) begin
          txCnt_r  <= BIT_CYC - 16'd1;
          txSh_r   <= {1'b1, txSh_r[9:1]};
          txBits_r <= txBits_r - 4'h1;
          if (txBits_r == 4'h1) begin
            txBusy <= 1'b0;
            txDone <= 1'b1;
          end
        end else begin
          txCnt_r <= txCnt_r - 16'd1;
        end
      end
      // Infrared: short high pulse per zero bit, idle low
      // Standard: plain bit, idle high
      serialOut <= irMode ? irPulse : curBit;
    end
  end

  // ----
  // Receiver
  // ----
  // IR input idles low; a pulse (a zero bit) is
  // stretched one bit time for the frame logic.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irHold_r <= 16'h0000;
      rxLine_r <= 1'b1;
    end else begin
      if (serialIn)
        irHold_r <= BIT_CYC - 16'd1;
      else if (irHold_r != 16'h0000)
        irHold_r <= irHold_r - 16'd1;
      rxLine_r <= irMode ? ~(serialIn | (irHold_r != 16'h0000))
                         : serialIn;
    end
  end

  // Frame state machine, samples at mid-bit
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxSt_r   <= R_IDLE;
      rxCnt_r  <= 16'h0000;
      rxBits_r <= 4'h0;
      rxSh_r   <= 8'h00;
      rxByte   <= 8'h00;
      rxFull   <= 1'b0;
      rxReadyN <= 1'b1;
      rtsN     <= 1'b1;
      rxDone   <= 1'b0;
      rxErr    <= 1'b0;
    end else begin
      rxDone <= rxGot;
      rxErr  <= (rxGot & rxFull & ~rxRead) |
                ((rxSt_r == R_STOP) && (rxCnt_r == 16'h0000) &&
                 !rxLine_r);
      if (rxCnt_r != 16'h0000)
        rxCnt_r <= rxCnt_r - 16'd1;
      case (rxSt_r)
        R_IDLE: begin
          if (!rxLine_r) begin
            rxSt_r  <= R_START;
            rxCnt_r <= HALF;
          end
        end
        R_START: begin
          if (rxCnt_r == 16'h0000) begin
            rxSt_r   <= rxLine_r ? R_IDLE : R_DATA;
            rxCnt_r  <= BIT_CYC - 16'd1;
            rxBits_r <= 4'h8;
          end
        end
        R_DATA: begin
          if (rxCnt_r == 16'h0000) begin
            rxSh_r   <= {rxLine_r, rxSh_r[7:1]};
            rxBits_r <= rxBits_r - 4'h1;
            rxCnt_r  <= BIT_CYC - 16'd1;
            if (rxBits_r == 4'h1)
              rxSt_r <= R_STOP;
          end
        end
        default: begin
          if (rxCnt_r == 16'h0000)
            rxSt_r <= R_IDLE;
        end
      endcase
      if (rxGot)
        rxByte <= rxSh_r;
      rxFull   <= fullNxt;                              // New byte wins
      rxReadyN <= ~fullNxt;
      rtsN     <= ~(rtsBit & ~(autoRts & fullNxt));
    end
  end

endmodule // dur_chan

// >>> rtl/dur_top.v
// Dual serial channel pin block with AXI4-Lite register access
//
// Summary of operation
// - Active-low receive-ready shows an unread received byte.
// - Infrared bit zero: plain serial transmit and receive.
// - Plain mode: transmit high in reset and when idle.
// - Infrared bit one: data through infrared encoder and decoder.
// - Infrared: encoder idles low, decoder takes low as inactive.
// - RTS active-low output; software asserts it before auto RTS.
// - CTS active-low input; gates transmit under auto CTS.
// - DTR is an active-low software output only.
// - DSR, CD and RI are readable inputs; a change sets the modem interrupt status.
// - Port-2 bit one: interrupt driven, port-2 pin low.
// - Port-2 bit zero: interrupt released, port-2 pin high.
// - Port-2 bit resets to zero: interrupt released, pin high.
// - Reset holds transmit high and ignores receive.
`timescale 1ns/1ps
`include "dur_defs.vh"

module dur_top #(
  parameter [15:0] BIT_CYC = `DUR_BIT_CYC,
  parameter        ADDR_W  = 8
) (
  input  wire              clk,
  input  wire              rst_b,
  // AXI4-Lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Channel A pins
  output wire              serial_out_a,
  input  wire              serial_in_a,
  output wire              request_send_n_a,
  input  wire              clear_send_n_a,
  output reg               terminal_ready_n_a,
  input  wire              set_ready_n_a,
  input  wire              carrier_detect_n_a,
  input  wire              ring_indicator_n_a,
  output reg               output_port2_n_a,
  output reg               irq_out_a,
  output reg               irq_out_oe_a,
  output wire              rx_ready_n_a,
  // Channel B pins
  output wire              serial_out_b,
  input  wire              serial_in_b,
  output wire              request_send_n_b,
  input  wire              clear_send_n_b,
  output reg               terminal_ready_n_b,
  input  wire              set_ready_n_b,
  input  wire              carrier_detect_n_b,
  input  wire              ring_indicator_n_b,
  output reg               output_port2_n_b,
  output reg               irq_out_b,
  output reg               irq_out_oe_b,
  output wire              rx_ready_n_b
);

  // ----
  // Register storage, one entry per channel
  // ----
  reg  [7:0]        mctl_r [0:1];
  reg  [7:0]        feat_r [0:1];
  reg  [7:0]        ien_r  [0:1];
  reg  [3:0]        ist_r  [0:1];
  reg  [3:0]        imsk_r [0:1];
  reg  [3:0]        mdm_r  [0:1];   // Asserted levels {cd, ri, dsr, cts}
  reg  [ADDR_W-1:0] awAddr_r;
  reg  [7:0]        wData_r;
  reg               wLane_r;
  reg  [31:0]       rdData;
  reg               rdOk;
  integer           i;

  // Pins gathered per channel
  wire [1:0] serIn  = {serial_in_b, serial_in_a};
  wire [1:0] ctsN   = {clear_send_n_b, clear_send_n_a};
  wire [3:0] mdmIn0 = ~{carrier_detect_n_a, ring_indicator_n_a,
                        set_ready_n_a, clear_send_n_a};
  wire [3:0] mdmIn1 = ~{carrier_detect_n_b, ring_indicator_n_b,
                        set_ready_n_b, clear_send_n_b};

  // Channel outputs
  wire [1:0] serOut;
  wire [1:0] rtsN;
  wire [1:0] rxRdyN;
  wire [1:0] txBusy;
  wire [1:0] txFull;
  wire [1:0] rxFull;
  wire [1:0] txDone;
  wire [1:0] rxDone;
  wire [1:0] rxErr;
  wire [7:0] rxByte [0:1];

  // ----
  // Write and read decode
  // ----
  wire       doWr   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire       wrCh   = awAddr_r[5];
  wire [2:0] wrIdx  = awAddr_r[4:2];
  wire       wrOk   = (awAddr_r >> 6) == {ADDR_W{1'b0}};
  wire       wrByte = doWr & wrOk & wLane_r;
  wire       rdTake = s_axi_arvalid & s_axi_arready;
  wire       rdCh   = s_axi_araddr[5];
  wire [2:0] rdIdx  = s_axi_araddr[4:2];
  wire [1:0] txLoad;
  wire [1:0] rxRead;

  assign txLoad[0] = wrByte & ~wrCh & (wrIdx == `DUR_IDX_TXD);
  assign txLoad[1] = wrByte &  wrCh & (wrIdx == `DUR_IDX_TXD);
  // Reading the receive data register frees the holding register
  assign rxRead[0] = rdTake & rdOk & ~rdCh & (rdIdx == `DUR_IDX_RXD);
  assign rxRead[1] = rdTake & rdOk &  rdCh & (rdIdx == `DUR_IDX_RXD);

  // ----
  // Channel instances
  // ----
  // Two copies of one module, each with its own control bits
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gCh
      dur_chan #(
        .BIT_CYC (BIT_CYC)
      ) uChan (
        .clk       (clk),
        .rst_b     (rst_b),
        .txLoad    (txLoad[g]),
        .txByte    (wData_r),
        .rxRead    (rxRead[g]),
        .irMode    (mctl_r[g][`DUR_MC_IR]),
        .autoCts   (feat_r[g][`DUR_FE_ACTS] &
                    ien_r[g][`DUR_FE_ACTS]),
        .autoRts   (feat_r[g][`DUR_FE_ARTS] &
                    ien_r[g][`DUR_FE_ARTS]),
        .rtsBit    (mctl_r[g][`DUR_MC_RTS]),
        .ctsN      (ctsN[g]),
        .serialIn  (serIn[g]),
        .serialOut (serOut[g]),
        .rtsN      (rtsN[g]),
        .rxReadyN  (rxRdyN[g]),
        .txBusy    (txBusy[g]),
        .txFull    (txFull[g]),
        .rxFull    (rxFull[g]),
        .rxByte    (rxByte[g]),
        .txDone    (txDone[g]),
        .rxDone    (rxDone[g]),
        .rxErr     (rxErr[g])
      );
    end
  endgenerate

  assign serial_out_a     = serOut[0];
  assign serial_out_b     = serOut[1];
  assign request_send_n_a = rtsN[0];
  assign request_send_n_b = rtsN[1];
  assign rx_ready_n_a     = rxRdyN[0];
  assign rx_ready_n_b     = rxRdyN[1];

  // ----
  // AXI4-Lite write channel
  // ----
  // Address and data in either order; response one cycle
  // after both, readies reopen on bready.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DUR_RESP_OK;
      awAddr_r      <= {ADDR_W{1'b0}};
      wData_r       <= 8'h00;
      wLane_r       <= 1'b0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        awAddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wData_r      <= s_axi_wdata[7:0];
        wLane_r      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (doWr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrOk ? `DUR_RESP_OK : `DUR_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----
  // Read mux
  // ----
  // Upper bits read as zero; addresses above both channels are errors
  always @* begin
    rdData = 32'h0000_0000;
    rdOk   = (s_axi_araddr >> 6) == {ADDR_W{1'b0}};
    if (rdIdx == `DUR_IDX_RXD) begin
      rdData[7:0] = rxByte[rdCh];
    end else if (rdIdx == `DUR_IDX_MCTL) begin
      rdData[7:0] = mctl_r[rdCh];
    end else if (rdIdx == `DUR_IDX_FEAT) begin
      rdData[7:0] = feat_r[rdCh];
    end else if (rdIdx == `DUR_IDX_IEN) begin
      rdData[7:0] = ien_r[rdCh];
    end else if (rdIdx == `DUR_IDX_STAT) begin
      rdData[`DUR_ST_RXF] = rxFull[rdCh];
      rdData[`DUR_ST_TXB] = txBusy[rdCh];
      rdData[`DUR_ST_TXF] = txFull[rdCh];
      rdData[7:4]         = mdm_r[rdCh];
    end else if (rdIdx == `DUR_IDX_IST) begin
      rdData[3:0] = ist_r[rdCh];
    end else if (rdIdx == `DUR_IDX_IMSK) begin
      rdData[3:0] = imsk_r[rdCh];
    end
    if (!rdOk)
      rdData = 32'h0000_0000;
  end

  // ----
  // AXI4-Lite read channel
  // ----
  // Data is captured at the address handshake and offered next cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DUR_RESP_OK;
    end else begin
      if (rdTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdData;
        s_axi_rresp   <= rdOk ? `DUR_RESP_OK : `DUR_RESP_ERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----
  // Control registers, modem sampling and interrupt status
  // ----
  // A hardware event in the same cycle as a write-one clear stays set.
  // Modem inputs feed status and the change event; CTS also gates the
  // transmit path under auto CTS, and none reach the receive path.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 2; i = i + 1) begin
        mctl_r[i] <= `DUR_RST_REG;
        feat_r[i] <= `DUR_RST_REG;
        ien_r[i]  <= `DUR_RST_REG;
        ist_r[i]  <= 4'h0;
        imsk_r[i] <= 4'h0;
        mdm_r[i]  <= 4'h0;
      end
    end else begin
      mdm_r[0] <= mdmIn0;
      mdm_r[1] <= mdmIn1;
      for (i = 0; i < 2; i = i + 1) begin
        if (wrByte && (wrCh == i[0])) begin
          if (wrIdx == `DUR_IDX_MCTL)
            mctl_r[i] <= wData_r;
          else if (wrIdx == `DUR_IDX_FEAT)
            feat_r[i] <= wData_r;
          else if (wrIdx == `DUR_IDX_IEN)
            ien_r[i] <= wData_r;
          else if (wrIdx == `DUR_IDX_IMSK)
            imsk_r[i] <= wData_r[3:0];
          else if (wrIdx == `DUR_IDX_IST)
            ist_r[i] <= ist_r[i] & ~wData_r[3:0];
        end
        // Set after clear so that a simultaneous event wins
        if (rxDone[i])
          ist_r[i][`DUR_IS_RXD] <= 1'b1;
        if (txDone[i])
          ist_r[i][`DUR_IS_TXD] <= 1'b1;
        if (rxErr[i])
          ist_r[i][`DUR_IS_RXE] <= 1'b1;
        if (mdm_r[i] != (i[0] ? mdmIn1 : mdmIn0))
          ist_r[i][`DUR_IS_MDM] <= 1'b1;
      end
    end
  end

  // ----
  // Pin outputs from control bits
  // ----
  // Interrupt pin shares its control bit with port 2, so a design
  // cannot use both independently.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      terminal_ready_n_a <= 1'b1;
      terminal_ready_n_b <= 1'b1;
      output_port2_n_a   <= 1'b1;
      output_port2_n_b   <= 1'b1;
      irq_out_oe_a       <= 1'b0;
      irq_out_oe_b       <= 1'b0;
      irq_out_a          <= 1'b0;
      irq_out_b          <= 1'b0;
    end else begin
      terminal_ready_n_a <= ~mctl_r[0][`DUR_MC_DTR];
      terminal_ready_n_b <= ~mctl_r[1][`DUR_MC_DTR];
      output_port2_n_a   <= ~mctl_r[0][`DUR_MC_OP2];
      output_port2_n_b   <= ~mctl_r[1][`DUR_MC_OP2];
      irq_out_oe_a       <= mctl_r[0][`DUR_MC_OP2];
      irq_out_oe_b       <= mctl_r[1][`DUR_MC_OP2];
      irq_out_a          <= |(ist_r[0] & imsk_r[0]);
      irq_out_b          <= |(ist_r[1] & imsk_r[1]);
    end
  end

endmodule // dur_top

// >>> bench/dur_top_props.sv
// Concurrent checks on the dual serial pin block ports
`timescale 1ns/1ps
module dur_top_props #(
  parameter ADDR_W = 8
) (
  input wire              clk,
  input wire              rst_b,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire              s_axi_bvalid,
  input wire              serial_out_a,
  input wire              serial_out_b,
  input wire              terminal_ready_n_a,
  input wire              request_send_n_a,
  input wire              output_port2_n_a,
  input wire              output_port2_n_b,
  input wire              irq_out_oe_a,
  input wire              irq_out_oe_b,
  input wire              rx_ready_n_a,
  input wire              rx_ready_n_b
);
  // ----
  // Pin relations
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Read handshake, used to tie receive-ready release to a data read
  wire rdTake = s_axi_arvalid && s_axi_arready;
  AST_OP2_A: assert property (output_port2_n_a == !irq_out_oe_a)
    else $error("port2 pin and irq enable disagree on A");
  AST_OP2_B: assert property (output_port2_n_b == !irq_out_oe_b)
    else $error("port2 pin and irq enable disagree on B");
  AST_TX_RESET: assert property (disable iff (1'h0)
    !rst_b |-> serial_out_a && serial_out_b)
    else $error("transmit line not high in reset");
  AST_RST_A: assert property ($rose(rst_b) |-> output_port2_n_a
    && !irq_out_oe_a && terminal_ready_n_a && request_send_n_a)
    else $error("channel A pins wrong after reset");
  AST_RST_B: assert property ($rose(rst_b) |-> output_port2_n_b
    && !irq_out_oe_b && rx_ready_n_b && serial_out_b)
    else $error("channel B pins wrong after reset");
  AST_RXRD_A: assert property (rdTake && s_axi_araddr == 8'h04
    |-> ##[1:2] rx_ready_n_a)
    else $error("receive ready A not released by read");
  AST_RXRD_B: assert property (rdTake && s_axi_araddr == 8'h24
    |-> ##[1:2] rx_ready_n_b)
    else $error("receive ready B not released by read");
  AST_OE_WR: assert property ($rose(irq_out_oe_a) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("irq enable rose without a write");
  cover property (rdTake && s_axi_araddr == 8'h04 && !rx_ready_n_a);
  cover property ($rose(irq_out_oe_a));
  cover property ($fell(serial_out_b));
endmodule // dur_top_props

// >>> bench/dur_line_model.sv
// Far-end line model: sends and collects 8N1 frames
`timescale 1ns/1ps
module dur_line_model #(
  parameter BIT_CYC = 8
) (
  input  wire clk,
  input  wire irMode,
  input  wire txLine,
  output wire rxLine
);
  // ----
  // Line drive
  // ----
  reg busy = 1'h0;
  reg lvl  = 1'h1;
  // Idle: pulled up when plain, dark when infrared
  assign rxLine = busy ? lvl : ~irMode;
  // Short high pulse per zero bit in infrared, plain levels otherwise
  task sendByte(input [7:0] b);
    integer i, c;
    reg [9:0] f;
    begin
      f = {1'h1, b, 1'h0};
      busy <= 1'h1;
      for (i = 0; i < 10; i = i + 1)
        for (c = 0; c < BIT_CYC; c = c + 1) begin
          lvl <= irMode ? (!f[i] && c < 3) : f[i];
          @(posedge clk);
        end
      busy <= 1'h0;
    end
  endtask
  // Mid-bit sampling; a line that never starts gives ok low
  task getByte(output [7:0] b, output ok);
    integer i;
    begin
      for (i = 0; i < 4000 && txLine; i = i + 1) @(posedge clk);
      ok = !txLine;
      repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk);
      for (i = 0; i < 8; i = i + 1) begin
        b[i] = txLine;
        repeat (BIT_CYC) @(posedge clk);
      end
    end
  endtask
endmodule // dur_line_model

// >>> bench/tb_top.sv
// Self-checking bench for the dual serial pin block
`timescale 1ns/1ps
module tb_top;
  localparam BC = 8;
  reg        clk = 1'h0, rst_b = 1'h1, irA = 1'h0, okV;
  reg        ring_indicator_n_b = 1'h1;
  reg [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, gotB;
  reg [31:0] s_axi_wdata = 32'h0, rdV;
  reg [3:0]  s_axi_wstrb = 4'hF;
  reg        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  reg        clear_send_n_a = 1'h1, set_ready_n_a = 1'h1;
  reg        carrier_detect_n_a = 1'h1, ring_indicator_n_a = 1'h1;
  wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire       s_axi_rvalid, serial_out_a, serial_in_a, request_send_n_a;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire       terminal_ready_n_a, output_port2_n_a, irq_out_a, irq_out_oe_a;
  wire       rx_ready_n_a, serial_out_b, request_send_n_b, irq_out_b;
  wire       terminal_ready_n_b, output_port2_n_b, irq_out_oe_b, rx_ready_n_b;
  wire       serial_in_b = serial_out_b; // Channel B looped on itself
  reg [1:0]  rsV;
  reg [11:0] rows [0:4];
  integer    errTotal = 0, compares = 0, ch, r, n, hi;
  // ----
  // Device, far end and clock
  // ----
  dur_top #(.BIT_CYC(BC)) dur_top_i (.clk, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .serial_out_a, .serial_in_a, .request_send_n_a,
    .clear_send_n_a, .terminal_ready_n_a, .set_ready_n_a, .carrier_detect_n_a,
    .ring_indicator_n_a, .output_port2_n_a, .irq_out_a, .irq_out_oe_a,
    .rx_ready_n_a, .serial_out_b, .serial_in_b, .request_send_n_b,
    .clear_send_n_b(1'h0), .terminal_ready_n_b, .set_ready_n_b(1'h1),
    .carrier_detect_n_b(1'h1), .ring_indicator_n_b, .output_port2_n_b,
    .irq_out_b, .irq_out_oe_b, .rx_ready_n_b);
  dur_line_model #(.BIT_CYC(BC)) dur_line_model_i (.clk, .irMode(irA),
    .txLine(serial_out_a), .rxLine(serial_in_a));
  // 50 ns period
  initial forever #25 clk = ~clk;
  // ----
  // Tasks
  // ----
  task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        errTotal = errTotal + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task giveVerdict;
    begin
      $display("compares %0d errTotal %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // One AXI4-Lite write or read; each channel dropped once taken
  task axi(input wr, input [7:0] a, input [31:0] d);
    integer k;
    reg done;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      done = 1'h0;
      for (k = 0; k < 50 && !done; k = k + 1) begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        if (wr ? s_axi_bvalid : s_axi_rvalid) begin
          done = 1'h1;
          rdV = s_axi_rdata;
          rsV = wr ? s_axi_bresp : s_axi_rresp;
          s_axi_bready <= 1'h0;
          s_axi_rready <= 1'h0;
        end
      end
      if (!done) begin
        errTotal = errTotal + 1;
        giveVerdict;
      end
    end
  endtask
  // ----
  // Sequence: rows give modem control and {dtr, rts, port2, irq oe}
  // Port 2 is never driven as a general output here
  // ----
  initial begin
    rst_b <= 1'h0;
    rows[0] = 12'h00E;
    rows[1] = 12'h016;
    rows[2] = 12'h02A;
    rows[3] = 12'h08D;
    rows[4] = 12'h0B1;
    repeat (16) @(posedge clk);
    chk("rstPins", 32'h3C, 32'({serial_out_a, serial_out_b, rx_ready_n_a,
      output_port2_n_a, irq_out_oe_a, irq_out_a}));
    rst_b <= 1'h1;
    for (ch = 0; ch < 2; ch = ch + 1)
      for (r = 0; r < 5; r = r + 1) begin
        axi(1'h1, 8'(ch * 32 + 8), 32'(rows[r][11:4]));
        repeat (2) @(posedge clk);
        chk("pins", 32'(rows[r][3:0]), 32'(ch ? {terminal_ready_n_b,
          request_send_n_b, output_port2_n_b, irq_out_oe_b} :
          {terminal_ready_n_a, request_send_n_a, output_port2_n_a,
          irq_out_oe_a}));
      end
    // Modem inputs show in the status register
    {clear_send_n_a, set_ready_n_a, carrier_detect_n_a} <= 3'h0;
    ring_indicator_n_a <= 1'h0;
    axi(1'h0, 8'h14, 32'h0);
    chk("modemIn", 32'hF, 32'(rdV[7:4]));
    // Auto CTS holds a start until the far end clears
    clear_send_n_a <= 1'h1;
    axi(1'h1, 8'h0C, 32'hC0);
    axi(1'h1, 8'h10, 32'hC0);
    axi(1'h1, 8'h00, 32'hA5);
    repeat (30) @(posedge clk);
    chk("ctsHold", 32'h1, 32'(serial_out_a));
    clear_send_n_a <= 1'h0;
    dur_line_model_i.getByte(gotB, okV);
    chk("txByte", 32'hA5, 32'(gotB));
    chk("txStart", 32'h1, 32'(okV));
    repeat (2 * BC) @(posedge clk);
    chk("txIdle", 32'h1, 32'(serial_out_a));
    // Receive with auto RTS and interrupt raise, mask and clear
    axi(1'h1, 8'h1C, 32'h1);
    dur_line_model_i.sendByte(8'h3C);
    repeat (4) @(posedge clk);
    chk("rxFlow", 32'h3,
      32'({rx_ready_n_a, request_send_n_a, irq_out_a}));
    axi(1'h1, 8'h1C, 32'h0);
    repeat (2) @(posedge clk);
    chk("irqMask", 32'h0, 32'(irq_out_a));
    axi(1'h1, 8'h1C, 32'h1);
    repeat (2) @(posedge clk);
    chk("irqUnmsk", 32'h1, 32'(irq_out_a));
    axi(1'h0, 8'h04, 32'h0);
    chk("rxByte", 32'h3C, rdV);
    repeat (2) @(posedge clk);
    chk("rxDrain", 32'h2, 32'({rx_ready_n_a, request_send_n_a}));
    axi(1'h1, 8'h18, 32'hF);
    repeat (2) @(posedge clk);
    chk("irqClr", 32'h0, 32'(irq_out_a));
    axi(1'h0, 8'h40, 32'h0);
    chk("badRd", 32'h2, 32'({rdV, rsV})); // 0x40 is unmapped
    axi(1'h1, 8'h44, 32'h5);
    chk("badWr", 32'h2, 32'(rsV));
    // Infrared: the mode switch garbles a byte, so drain it first
    irA <= 1'h1;
    axi(1'h1, 8'h08, 32'h4B);
    repeat (200) @(posedge clk);
    axi(1'h0, 8'h04, 32'h0);
    axi(1'h1, 8'h18, 32'hF);
    chk("irIdle", 32'h0, 32'(serial_out_a));
    hi = 0;
    axi(1'h1, 8'h00, 32'h0);
    for (n = 0; n < 100; n = n + 1) begin
      @(posedge clk);
      hi = hi + serial_out_a;
    end
    chk("irPulse", 32'(9 * ((3 * BC + 15) / 16)), 32'(hi));
    dur_line_model_i.sendByte(8'h96);
    repeat (4) @(posedge clk);
    axi(1'h0, 8'h04, 32'h0);
    chk("irRx", 32'h96, rdV);
    // Channel B on its own loop
    axi(1'h1, 8'h20, 32'h5A);
    for (n = 0; n < 300 && rx_ready_n_b !== 1'h0; n = n + 1) @(posedge clk);
    chk("rxWaitB", 32'h0, 32'(n == 300));
    axi(1'h0, 8'h24, 32'h0);
    chk("chanB", 32'h5A, rdV);
    axi(1'h1, 8'h3C, 32'h8);
    axi(1'h1, 8'h38, 32'hF);
    ring_indicator_n_b <= 1'h0;
    repeat (3) @(posedge clk);
    chk("irqB", 32'h1, 32'(irq_out_b));
    // Second reset in mid-run
    irA <= 1'h0;
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    chk("rstTx", 32'h6, 32'({serial_out_a,
      output_port2_n_a, irq_out_oe_a}));
    rst_b <= 1'h1;
    repeat (2) @(posedge clk);
    giveVerdict;
  end
endmodule // tb_top

bind dur_top dur_top_props #(.ADDR_W(ADDR_W)) dur_top_props_i (.*);
